// File: wdt_pkg.sv
// watchdog timer with reset-cause flags: shared constants
// assumes a 40 MHz apb clock and a 128 kHz oscillator level sampled in that domain

package wdt_pkg;
   // ==========================================================
   // register map (byte addresses on apb)
   localparam logic [11:0] ADDR_CTRL = 12'h000; // watchdog control/status
   localparam logic [11:0] ADDR_CAUSE = 12'h004; // reset_cause_flags
   localparam logic [11:0] ADDR_COUNT = 12'h008; // live counter value

   // ==========================================================
   // control register fields
   localparam int CTRL_IRQ_FLAG = 7; // timeout_irq_flag
   localparam int CTRL_IRQ_EN = 6; // irq_enable_bit
   localparam int CTRL_WDP_HI = 5; // prescaler_select bit 3
   localparam int CTRL_CHG_EN = 4; // change_enable_bit
   localparam int CTRL_RST_EN = 3; // reset_enable_bit
   localparam int CTRL_WDP_LO = 0; // prescaler_select bits 2..0 start here

   // ==========================================================
   // reset_cause_flags fields and values after power-on
   localparam int CAUSE_POWERON = 0; // poweron_flag
   localparam int CAUSE_PIN = 1; // pin_reset_flag
   localparam int CAUSE_BROWNOUT = 2; // brownout_flag
   localparam int CAUSE_WDOG = 3; // wdog_reset_flag
   localparam int CAUSE_W = 4; // implemented flags
   localparam logic [3:0] CAUSE_RESET_VAL = 4'h1; // only power-on set
   localparam logic [3:0] WDP_RESET_VAL = 4'h0; // shortest period

   // ==========================================================
   // timing
   localparam int OSC_FREQ_KHZ = 128; // watchdog oscillator rate
   localparam int TIMEOUT_MIN_MS = 16; // code 0 period
   localparam int TIMEOUT_MAX_MS = 8000; // code 9 period
   localparam int BASE_CYCLES = TIMEOUT_MIN_MS * OSC_FREQ_KHZ; // 2048 oscillator cycles
   localparam logic [3:0] WDP_MAX_CODE = 4'h9; // longest legal code
   localparam int CNT_W = 21; // holds 1048576
   localparam logic [2:0] CHG_WINDOW_CYCLES = 3'h4; // unlock window length
   localparam int CLK_PERIOD_NS = 25; // 40 MHz core clock
   localparam int STARTUP_DELAY_NS = 65000; // startup_delay_period
   localparam int STARTUP_CYCLES = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : wdt_pkg

// File: wdt_startup_delay.sv
// start-up delay counter stretching the internal reset after a watchdog reset
// assumes the trigger is a one-cycle pulse in the pclk domain
`timescale 1ns/1ps

module wdt_startup_delay #(
   parameter int DELAY_CYCLES = wdt_pkg::STARTUP_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reset_pulse,
   output logic hold
);
   // ==========================================================
   // falling edge of the reset pulse
   logic pulse_prev_q; // pulse one cycle ago
   logic fall; // trailing edge seen
   logic [15:0] cnt_q; // cycles left

   assign fall = pulse_prev_q & ~reset_pulse;

   // edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_prev_q <= 1'b0;
      end else begin
         pulse_prev_q <= reset_pulse;
      end
   end

   // delay down-counter, loaded on the trailing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
      end else if (fall) begin
         cnt_q <= 16'(DELAY_CYCLES);
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   // hold is a flop decode, so no glitch reaches the reset tree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= 1'b0;
      end else begin
         hold <= fall | (cnt_q > 16'h0001);
      end
   end

   a_hold_start: assert property (@(posedge pclk) disable iff (!presetn)
      fall |=> hold) else $error("start-up hold did not begin after pulse");
endmodule : wdt_startup_delay

// File: wdt_watchdog.sv
// watchdog timer core with timed setup unlock and reset-cause flags, apb slave
// assumes osc_level toggles at 128 kHz and is synchronous to pclk
`timescale 1ns/1ps

module wdt_watchdog #(
   parameter int STARTUP_CYCLES = wdt_pkg::STARTUP_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_level,
   input wire logic wdog_restart,
   input wire logic irq_vector_ack,
   input wire logic always_on_fuse,
   input wire logic pin_reset_evt,
   input wire logic brownout_evt,
   output logic wdog_irq,
   output logic wdog_reset_pulse,
   output logic core_reset_hold
);
   // ==========================================================
   // declarations
   localparam int CAUSE_W_L = wdt_pkg::CAUSE_W; // implemented cause flags
   logic re_q; // reset_enable_bit as written
   logic ie_q; // irq_enable_bit as written
   logic [3:0] wdp_q; // prescaler_select
   logic [2:0] chg_cnt_q; // unlock window cycles left
   logic irq_flag_q; // timeout_irq_flag
   logic [CAUSE_W_L-1:0] cause_q; // reset_cause_flags
   logic osc_q; // oscillator level last cycle
   logic tick; // one oscillator period elapsed
   logic [wdt_pkg::CNT_W-1:0] cnt_q; // watchdog counter
   logic [wdt_pkg::CNT_W-1:0] limit; // selected terminal count
   logic rst_pulse_q; // one-cycle system reset
   logic re_eff; // reset enable after overrides
   logic ie_eff; // irq enable after fuse
   logic running; // any mode active
   logic expire; // terminal count this cycle
   logic expire_irq; // expiry gives interrupt
   logic expire_rst; // expiry gives reset
   logic wr_ctrl; // write to control
   logic wr_cause; // write to cause flags
   logic chg_open; // change window open
   logic unlock; // unlock write seen
   logic cfg_apply; // setup write inside window
   logic [3:0] wdp_new; // prescaler from bus
   logic presc_chg; // prescaler about to change
   logic setup_phase; // apb setup cycle
   logic [3:0] cause_set; // hardware set per flag

   // ==========================================================
   // apb decode
   assign setup_phase = psel & ~penable;
   assign wr_ctrl = psel & penable & pwrite & (paddr == wdt_pkg::ADDR_CTRL);
   assign wr_cause = psel & penable & pwrite & (paddr == wdt_pkg::ADDR_CAUSE);
   // writes land only at the access edge, never in the setup cycle
   assign pready = 1'b1; // zero wait states
   // unmapped access answers with an error in the access phase
   assign pslverr = psel & penable & (paddr != wdt_pkg::ADDR_CTRL) &
                    (paddr != wdt_pkg::ADDR_CAUSE) & (paddr != wdt_pkg::ADDR_COUNT);

   // ==========================================================
   // effective mode
   // fuse wins over software; a set watchdog flag pins reset enable high
   assign re_eff = re_q | cause_q[wdt_pkg::CAUSE_WDOG] | always_on_fuse;
   assign ie_eff = ie_q & ~always_on_fuse;
   // with the fuse set the stored irq enable still takes writes, but stays unseen
   assign running = re_eff | ie_eff;

   // ==========================================================
   // timed setup sequence
   assign chg_open = (chg_cnt_q != 3'h0);
   // unlock needs both bits in one write, whatever reset enable held
   assign unlock = wr_ctrl & pwdata[wdt_pkg::CTRL_CHG_EN] & pwdata[wdt_pkg::CTRL_RST_EN];
   assign cfg_apply = wr_ctrl & ~pwdata[wdt_pkg::CTRL_CHG_EN] & chg_open;
   assign wdp_new = {pwdata[wdt_pkg::CTRL_WDP_HI], pwdata[wdt_pkg::CTRL_WDP_LO +: 3]};
   assign presc_chg = cfg_apply & (wdp_new != wdp_q);

   // window counter: opened by unlock, closed by use or by age
   // counted in pclk cycles, so a master with wait states may miss the window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chg_cnt_q <= 3'h0;
      end else if (unlock) begin
         chg_cnt_q <= wdt_pkg::CHG_WINDOW_CYCLES;
      end else if (cfg_apply) begin
         chg_cnt_q <= 3'h0; // one change per unlock
      end else if (chg_open) begin
         chg_cnt_q <= chg_cnt_q - 3'h1;
      end
   end

   // reset enable and prescaler
   // these survive the block's own system reset, so an accidental enable persists
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         re_q <= 1'b0;
         wdp_q <= wdt_pkg::WDP_RESET_VAL;
      end else if (cfg_apply) begin
         // clearing is refused while the watchdog flag stands
         re_q <= pwdata[wdt_pkg::CTRL_RST_EN] | cause_q[wdt_pkg::CAUSE_WDOG];
         wdp_q <= wdp_new;
      end else if (wr_ctrl && pwdata[wdt_pkg::CTRL_RST_EN]) begin
         re_q <= 1'b1; // setting needs no unlock
      end else if (rst_pulse_q) begin
         re_q <= 1'b1;
      end
   end

   // interrupt enable; vector in combined mode drops to reset mode
   // a bus write and the vector can meet in one cycle; the vector wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_q <= 1'b0;
      end else if (irq_vector_ack && re_eff) begin
         ie_q <= 1'b0;
      end else if (wr_ctrl) begin
         ie_q <= pwdata[wdt_pkg::CTRL_IRQ_EN];
      end
   end

   // ==========================================================
   // oscillator tick and counter
   // the input is already pclk-synchronous, so one flop gives the edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= osc_level;
      end
   end
   // limitation: a level toggling on every pclk edge would lose ticks
   assign tick = osc_level & ~osc_q;

   // terminal count: 2048 shifted by code; reserved codes behave as the longest
   always_comb begin
      if (wdp_q > wdt_pkg::WDP_MAX_CODE) begin
         limit = wdt_pkg::CNT_W'(wdt_pkg::BASE_CYCLES << wdt_pkg::WDP_MAX_CODE);
      end else begin
         limit = wdt_pkg::CNT_W'(wdt_pkg::BASE_CYCLES << wdp_q);
      end
   end

   assign expire = tick & running & (cnt_q == limit - wdt_pkg::CNT_W'(1));
   // combined mode: flag still pending at second expiry means reset
   assign expire_irq = expire & ie_eff & ~(re_eff & irq_flag_q);
   assign expire_rst = expire & re_eff & (~ie_eff | irq_flag_q);

   // counter restarts on restart instruction, period change, stop or expiry
   // clearing on a period change costs a longer first period but no false expiry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (wdog_restart || presc_chg || !running || expire) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + wdt_pkg::CNT_W'(1);
      end
   end

   // ==========================================================
   // interrupt flag: set wins over any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_q <= 1'b0;
      end else if (expire_irq) begin
         irq_flag_q <= 1'b1;
      end else if (irq_vector_ack || (wr_ctrl && pwdata[wdt_pkg::CTRL_IRQ_FLAG])) begin
         irq_flag_q <= 1'b0;
      end
   end
   // level request; also usable as wake source while the core sleeps
   assign wdog_irq = irq_flag_q & ie_eff;

   // ==========================================================
   // system reset pulse and start-up stretch
   // a flop keeps the pulse glitch free and exactly one pclk wide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= expire_rst;
      end
   end
   assign wdog_reset_pulse = rst_pulse_q;

   wdt_startup_delay #(
      .DELAY_CYCLES(STARTUP_CYCLES)
   ) u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .reset_pulse(rst_pulse_q),
      .hold(core_reset_hold)
   );

   // ==========================================================
   // reset-cause flags, one flop per flag
   // presetn is the power-on reset: it sets the power-on flag, clears the rest
   // ones written are ignored, so a read-modify-write of one flag is safe
   assign cause_set = {expire_rst, brownout_evt, pin_reset_evt, 1'b0};
   generate
      for (genvar i = 0; i < CAUSE_W_L; i++) begin : g_cause
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cause_q[i] <= wdt_pkg::CAUSE_RESET_VAL[i];
            end else if (cause_set[i]) begin
               cause_q[i] <= 1'b1; // event beats a same-cycle clear
            end else if (wr_cause && !pwdata[i]) begin
               cause_q[i] <= 1'b0; // writing one leaves the flag alone
            end
         end
      end
   endgenerate

   // ==========================================================
   // read data, captured in the setup cycle
   // capturing early keeps prdata a flop output through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_phase) begin
         if (paddr == wdt_pkg::ADDR_CTRL) begin
            prdata <= {24'h000000, irq_flag_q, ie_eff, wdp_q[3], chg_open, re_eff, wdp_q[2:0]};
         end else if (paddr == wdt_pkg::ADDR_CAUSE) begin
            prdata <= {28'h0000000, cause_q};
         end else if (paddr == wdt_pkg::ADDR_COUNT) begin
            prdata <= {11'h000, cnt_q};
         end else begin
            prdata <= 32'h00000000; // unmapped
         end
      end
   end

   // ==========================================================
   // checks
   // every check samples on pclk and rests while presetn is low
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pulse_one_cycle: assert property (wdog_reset_pulse |=> !wdog_reset_pulse)
      else $error("watchdog reset pulse longer than one cycle");
   a_hold_after_fall: assert property ($fell(wdog_reset_pulse) |=> core_reset_hold)
      else $error("start-up hold missing after reset pulse");
   a_cause_upper_zero: assert property (setup_phase && paddr == wdt_pkg::ADDR_CAUSE |=> prdata[31:4] == 28'h0)
      else $error("cause register upper bits not zero");
   a_wdog_flag_set: assert property (wdog_reset_pulse |-> cause_q[wdt_pkg::CAUSE_WDOG])
      else $error("watchdog flag not set by watchdog reset");
   a_brownout_flag: assert property (brownout_evt |=> cause_q[wdt_pkg::CAUSE_BROWNOUT])
      else $error("brown-out flag not set");
   a_pin_flag: assert property (pin_reset_evt |=> cause_q[wdt_pkg::CAUSE_PIN])
      else $error("pin reset flag not set");
   a_poweron_kept: assert property (!(wr_cause && !pwdata[0]) && cause_q[0] |=> cause_q[0])
      else $error("power-on flag lost without software clear");
   a_fuse_forces: assert property (always_on_fuse |-> re_eff && !ie_eff && !wdog_irq)
      else $error("always-on fuse not forcing reset mode");
   a_flag_holds_re: assert property (cause_q[wdt_pkg::CAUSE_WDOG] |=> re_q)
      else $error("reset enable dropped while watchdog flag set");
   a_window_closes: assert property (unlock ##1 (!unlock && !cfg_apply) [*4] |=> !chg_open)
      else $error("change window open longer than four cycles");
   a_locked_wdp: assert property (wr_ctrl && !chg_open |=> wdp_q == $past(wdp_q))
      else $error("prescaler changed outside unlock window");
   a_irq_mode: assert property (expire && ie_eff && !re_eff |=> irq_flag_q && !wdog_reset_pulse)
      else $error("interrupt mode expiry gave no interrupt");
   a_reset_mode: assert property (expire && re_eff && !ie_eff |=> wdog_reset_pulse ##2 core_reset_hold)
      else $error("reset mode expiry gave no reset");
   a_combined_first: assert property (expire && re_eff && ie_eff && !irq_flag_q |=> irq_flag_q && !wdog_reset_pulse)
      else $error("combined mode first expiry wrong");
   a_restart_zero: assert property (wdog_restart |=> cnt_q == '0)
      else $error("restart did not clear counter");
   a_presc_restart: assert property (presc_chg |=> cnt_q == '0)
      else $error("prescaler change did not restart counter");

   // interrupt flag, vector and combined-mode hand-over
   a_irq_clear: assert property (irq_vector_ack && !expire_irq |=> !irq_flag_q)
      else $error("vector did not clear interrupt flag");
   a_vector_to_reset: assert property (irq_vector_ack && re_eff |=> !ie_q)
      else $error("vector did not drop to reset mode");
   a_combined_reset: assert property (expire && re_eff && irq_flag_q |=> wdog_reset_pulse)
      else $error("second expiry in combined mode gave no reset");

   // counter and setup window
   a_stopped_idle: assert property (!running |=> cnt_q == '0)
      else $error("stopped watchdog counter not at zero");
   a_unlock_opens: assert property (unlock |=> chg_open)
      else $error("unlock write did not open change window");

   // reset-cause priorities
   a_pin_set_wins: assert property (pin_reset_evt && wr_cause && !pwdata[wdt_pkg::CAUSE_PIN] |=> cause_q[1])
      else $error("pin reset lost to same-cycle clear");
   a_wdog_flag_clear: assert property (wr_cause && !pwdata[wdt_pkg::CAUSE_WDOG] && !expire_rst |=> !cause_q[3])
      else $error("watchdog flag not cleared by software zero");

   c_reset_pulse: cover property (wdog_reset_pulse);
   c_cfg_apply: cover property (unlock ##[1:3] cfg_apply);
   c_irq_raise: cover property ($rose(irq_flag_q));
   c_combined_reset: cover property (irq_flag_q && expire_rst);
   c_vector_drop: cover property (irq_vector_ack && re_eff && ie_q);
endmodule : wdt_watchdog

// File: wdt_core_model.sv
// far-side model: oscillator stand-in, restart instruction and interrupt vector fetch
// assumes the bench raises kick_req or ack_req for one pclk at a time
`timescale 1ns/1ps

module wdt_core_model #(
   parameter int HALF = 2 // oscillator half period in pclk cycles
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic kick_req,
   input wire logic ack_req,
   output logic osc_level,
   output logic wdog_restart,
   output logic irq_vector_ack
);
   // ==========================================================
   // oscillator
   int cnt_q; // pclk cycles into the half period
   // runs free, far faster than 128 kHz, so a 2048-tick period fits a short run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         osc_level <= 1'b0;
      end else if (cnt_q == HALF - 1) begin
         cnt_q <= 0;
         osc_level <= ~osc_level; // one edge pair per tick
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end

   // ==========================================================
   // restart instruction and vector execution, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_restart <= 1'b0;
         irq_vector_ack <= 1'b0;
      end else begin
         wdog_restart <= kick_req;
         irq_vector_ack <= ack_req;
      end
   end
endmodule : wdt_core_model

// File: tb.sv
// self-checking bench for the watchdog with reset-cause flags
// assumes zero-wait apb and a fast oscillator from the core model
`timescale 1ns/1ps

module tb;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} wdt_exp_t; // expected read
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic osc_level, wdog_restart, irq_vector_ack, always_on_fuse, pin_reset_evt, brownout_evt;
   logic wdog_irq, wdog_reset_pulse, core_reset_hold, kick_req, ack_req;
   logic [15:0] lfsr_q; // random source for don't-care write bits
   wdt_exp_t exp_q[$]; // reads still awaiting their answer
   int error_cnt, n_checks, n;

   // ==========================================================
   // clock, design and far-side model
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   wdt_watchdog #(.STARTUP_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_level(osc_level), .wdog_restart(wdog_restart), .irq_vector_ack(irq_vector_ack),
      .always_on_fuse(always_on_fuse), .pin_reset_evt(pin_reset_evt), .brownout_evt(brownout_evt),
      .wdog_irq(wdog_irq), .wdog_reset_pulse(wdog_reset_pulse), .core_reset_hold(core_reset_hold));
   wdt_core_model #(.HALF(2)) core (.pclk(pclk), .presetn(presetn), .kick_req(kick_req), .ack_req(ack_req),
      .osc_level(osc_level), .wdog_restart(wdog_restart), .irq_vector_ack(irq_vector_ack));

   // ==========================================================
   // helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // read: note the expectation, the monitor compares it
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
      exp_q.push_back('{e, m, err});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic pulse_in(input int which); // 0 kick, 1 ack, 2 pin, 3 brown-out
      @(posedge pclk);
      case (which)
         0: kick_req <= 1'b1;
         1: ack_req <= 1'b1;
         2: pin_reset_evt <= 1'b1;
         default: brownout_evt <= 1'b1;
      endcase
      @(posedge pclk);
      {kick_req, ack_req, pin_reset_evt, brownout_evt} <= 4'h0;
   endtask : pulse_in
   task automatic wait_irq(input int lim); // bounded wait for the request
      n = 0;
      while (wdog_irq !== 1'b1 && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
      end
   endtask : wait_irq
   task automatic print_verdict;
      if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // monitor: completes each read against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         chk("prdata", exp_q[0].d, prdata & exp_q[0].m);
         chk("pslverr", {31'h0, exp_q[0].e}, {31'h0, pslverr});
         void'(exp_q.pop_front());
      end
   end

   // watchdog on the run itself, well above the expected length
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, always_on_fuse, pin_reset_evt, brownout_evt, kick_req, ack_req} = 9'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      error_cnt = 0;
      n_checks = 0;
      lfsr_q = 16'h7417;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, upper bits zero, unmapped place
      rd(wdt_pkg::ADDR_CAUSE, 32'h1, 32'hffffffff, 1'b0);
      rd(wdt_pkg::ADDR_CTRL, 32'h0, 32'hffffffff, 1'b0);
      rd(12'h00c, 32'h0, 32'hffffffff, 1'b1);
      // cause flags: set by events, ones written have no effect, zero clears
      pulse_in(2);
      pulse_in(3);
      lfsr_q = lfsr_next(lfsr_q);
      apb(1'b1, wdt_pkg::ADDR_CAUSE, {12'h0, lfsr_q, 4'hf});
      rd(wdt_pkg::ADDR_CAUSE, 32'h7, 32'hffffffff, 1'b0);
      apb(1'b1, wdt_pkg::ADDR_CAUSE, 32'h0);
      rd(wdt_pkg::ADDR_CAUSE, 32'h0, 32'hffffffff, 1'b0);
      // interrupt mode: a restart late in the period postpones expiry
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h40);
      pulse_in(0);
      repeat (1800 * 4) @(posedge pclk);
      pulse_in(0);
      repeat (2040 * 4) @(posedge pclk);
      #1;
      chk("wdog_irq", 32'h0, {31'h0, wdog_irq});
      wait_irq(80);
      chk("wdog_irq", 32'h1, {31'h0, wdog_irq});
      pulse_in(1);
      @(posedge pclk);
      #1;
      chk("wdog_irq", 32'h0, {31'h0, wdog_irq});
      // combined mode: interrupt on first expiry, reset on the next
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h48);
      pulse_in(0);
      wait_irq(2060 * 4);
      chk("wdog_irq", 32'h1, {31'h0, wdog_irq});
      chk("wdog_reset_pulse", 32'h0, {31'h0, wdog_reset_pulse});
      n = 0;
      while (wdog_reset_pulse !== 1'b1 && n < 2060 * 4) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("wdog_reset_pulse", 32'h1, {31'h0, wdog_reset_pulse});
      @(posedge pclk);
      #1;
      chk("wdog_reset_pulse", 32'h0, {31'h0, wdog_reset_pulse});
      @(posedge pclk);
      #1;
      n = 0;
      while (core_reset_hold === 1'b1 && n < 50) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("core_reset_hold", 32'd8, n);
      rd(wdt_pkg::ADDR_CAUSE, 32'h8, 32'h8, 1'b0);
      rd(wdt_pkg::ADDR_CTRL, 32'h8, 32'h8, 1'b0);
      // enable cannot be dropped while the watchdog flag stands
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h80);
      rd(wdt_pkg::ADDR_CTRL, 32'h8, 32'h8, 1'b0);
      apb(1'b1, wdt_pkg::ADDR_CAUSE, 32'h0);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h80);
      rd(wdt_pkg::ADDR_CTRL, 32'h0, 32'hffffffff, 1'b0);
      // a late second write finds the window closed
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h08);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
      repeat (6) @(posedge pclk);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h00);
      rd(wdt_pkg::ADDR_CTRL, 32'h8, 32'h18, 1'b0);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h21);
      rd(wdt_pkg::ADDR_CTRL, 32'h21, 32'hffffffff, 1'b0);
      // fuse forces reset mode whatever is written
      always_on_fuse <= 1'b1;
      rd(wdt_pkg::ADDR_CTRL, 32'h8, 32'h48, 1'b0);
      apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h40);
      rd(wdt_pkg::ADDR_CTRL, 32'h8, 32'h48, 1'b0);
      @(posedge pclk);
      print_verdict();
   end
endmodule : tb
